// file: ssr_ctrl_model.sv
`timescale 1ns/1ps
// ========
// remote controller: sees srq, asks for a poll
module ssr_ctrl_model (
  input  wire pclk,
  input  wire presetn,
  input  wire srq,
  output reg  poll_due
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      poll_due <= 1'h0;
    else
      poll_due <= srq;
  end
endmodule // ssr_ctrl_model

// file: ssr_defines.vh
`ifndef SSR_DEFINES_VH
`define SSR_DEFINES_VH

// =====================================================
// register byte offsets
`define SSR_OPER_COND   8'h00
`define SSR_OPER_PTR    8'h04
`define SSR_OPER_NTR    8'h08
`define SSR_OPER_EVENT  8'h0C
`define SSR_OPER_ENABLE 8'h10
`define SSR_QUES_COND   8'h14
`define SSR_QUES_PTR    8'h18
`define SSR_QUES_NTR    8'h1C
`define SSR_QUES_EVENT  8'h20
`define SSR_QUES_ENABLE 8'h24
`define SSR_STD_ENABLE  8'h28
`define SSR_STD_EVENT   8'h2C
`define SSR_SRQ_ENABLE  8'h30
`define SSR_STB_QUERY   8'h34
`define SSR_STB_POLL    8'h38
`define SSR_CLEAR_CMD   8'h3C
`define SSR_OPC_CMD     8'h40
`define SSR_PSC_FLAG    8'h44
`define SSR_PRESET_CMD  8'h48

// =====================================================
// field positions
`define SSR_W           16
`define SSR_MASK        16'h7FFF
`define SSR_SB_ERRQ     2
`define SSR_SB_QUES     3
`define SSR_SB_MAV      4
`define SSR_SB_STD      5
`define SSR_SB_RQS      6
`define SSR_SB_OPER     7
`define SSR_STD_OPC     0

// =====================================================
// reset and preset values
`define SSR_PTR_PRESET  15'h7FFF
`define SSR_NTR_PRESET  15'h0000
`define SSR_EN_PRESET   15'h0000
`define SSR_PSC_RESET   1'b1

`endif

// file: ssr_group.v
`timescale 1ns/1ps
// =====================================================
// one condition / filter / event / enable group
module ssr_group (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [14:0] cond_in,
  input  wire        wr_ptr,
  input  wire        wr_ntr,
  input  wire        wr_en,
  input  wire [15:0] wdata,
  input  wire        preset,
  input  wire        en_clear,
  input  wire [15:0] ev_clear,
  output wire [15:0] cond,
  output wire [15:0] ptr,
  output wire [15:0] ntr,
  output wire [15:0] event_bits,
  output wire [15:0] enable,
  output wire        summary
);
`include "ssr_defines.vh"

  reg  [14:0] cond_reg;
  reg  [14:0] ptr_reg;
  reg  [14:0] ntr_reg;
  reg  [14:0] event_reg;
  reg  [14:0] enable_reg;
  wire [14:0] hit;

  // =====================================================
  // per-bit transition filtering
  genvar i;
  generate
    for (i = 0; i < 15; i = i + 1) begin : g_bit
      assign hit[i] = (ptr_reg[i] & cond_in[i] & ~cond_reg[i]) |
                      (ntr_reg[i] & ~cond_in[i] & cond_reg[i]);
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cond_reg   <= 15'h0000;
      ptr_reg    <= `SSR_PTR_PRESET;
      ntr_reg    <= `SSR_NTR_PRESET;
      event_reg  <= 15'h0000;
      enable_reg <= `SSR_EN_PRESET;
    end else begin
      cond_reg  <= cond_in;
      // set wins over a read or clear in the same cycle
      event_reg <= (event_reg & ~ev_clear[14:0]) | hit;
      if (preset) begin
        ptr_reg    <= `SSR_PTR_PRESET;
        ntr_reg    <= `SSR_NTR_PRESET;
        enable_reg <= `SSR_EN_PRESET;
      end else begin
        if (wr_ptr)
          ptr_reg <= wdata[14:0];
        if (wr_ntr)
          ntr_reg <= wdata[14:0];
        if (en_clear)
          enable_reg <= 15'h0000;
        else if (wr_en)
          enable_reg <= wdata[14:0];
      end
    end
  end

  assign cond       = {1'b0, cond_reg};
  assign ptr        = {1'b0, ptr_reg};
  assign ntr        = {1'b0, ntr_reg};
  assign event_bits = {1'b0, event_reg};
  assign enable     = {1'b0, enable_reg};
  assign summary    = |(event_reg & enable_reg);

endmodule // ssr_group

// file: ssr_status.v
`timescale 1ns/1ps
// =====================================================
// status reporting and service request block, apb slave
module ssr_status (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  input  wire [14:0] oper_cond_in,
  input  wire [14:0] ques_cond_in,
  input  wire [14:0] std_event_in,
  input  wire        err_queue_nonempty,
  input  wire        msg_available,
  input  wire        cmds_idle,
  input  wire        power_restart,
  output reg         err_queue_clear,
  output wire        srq,
  output wire        request_service_summary
);
`include "ssr_defines.vh"

  // =====================================================
  // bus decode
  wire        setup  = psel & ~penable;
  wire        access = psel & penable;
  wire        opc_q  = ~pwrite & (paddr == `SSR_OPC_CMD);
  // completion query stalls the bus until all commands finish
  assign pready = ~(access & opc_q & ~cmds_idle);
  wire        done   = access & pready;
  wire        wr     = done & pwrite;
  wire        rd     = done & ~pwrite;
  wire [15:0] wd     = pwdata[15:0] & `SSR_MASK;

  // =====================================================
  // per-register strobes, for 16 of the 19 mapped offsets (none for the two condition registers or the status query)
  reg         wr_oper_ptr;
  reg         wr_oper_ntr;
  reg         wr_oper_en;
  reg         wr_ques_ptr;
  reg         wr_ques_ntr;
  reg         wr_ques_en;
  reg         wr_std_en;
  reg         wr_sre;
  reg         wr_cls;
  reg         wr_opc;
  reg         wr_psc;
  reg         wr_preset;
  reg         rd_oper_ev;
  reg         rd_ques_ev;
  reg         rd_std_ev;
  reg         rd_poll;

  always @* begin
    wr_oper_ptr = 1'b0;
    wr_oper_ntr = 1'b0;
    wr_oper_en  = 1'b0;
    wr_ques_ptr = 1'b0;
    wr_ques_ntr = 1'b0;
    wr_ques_en  = 1'b0;
    wr_std_en   = 1'b0;
    wr_sre      = 1'b0;
    wr_cls      = 1'b0;
    wr_opc      = 1'b0;
    wr_psc      = 1'b0;
    wr_preset   = 1'b0;
    rd_oper_ev  = 1'b0;
    rd_ques_ev  = 1'b0;
    rd_std_ev   = 1'b0;
    rd_poll     = 1'b0;
    case (paddr)
      `SSR_OPER_PTR:    wr_oper_ptr = wr;
      `SSR_OPER_NTR:    wr_oper_ntr = wr;
      `SSR_OPER_EVENT:  rd_oper_ev  = rd;
      `SSR_OPER_ENABLE: wr_oper_en  = wr;
      `SSR_QUES_PTR:    wr_ques_ptr = wr;
      `SSR_QUES_NTR:    wr_ques_ntr = wr;
      `SSR_QUES_EVENT:  rd_ques_ev  = rd;
      `SSR_QUES_ENABLE: wr_ques_en  = wr;
      `SSR_STD_ENABLE:  wr_std_en   = wr;
      `SSR_STD_EVENT:   rd_std_ev   = rd;
      `SSR_SRQ_ENABLE:  wr_sre      = wr;
      `SSR_STB_POLL:    rd_poll     = rd;
      `SSR_CLEAR_CMD:   wr_cls      = wr;
      `SSR_OPC_CMD:     wr_opc      = wr;
      `SSR_PSC_FLAG:    wr_psc      = wr;
      `SSR_PRESET_CMD:  wr_preset   = wr;
      default:          wr_cls      = 1'b0;
    endcase
  end

  // =====================================================
  // registers
  reg  [14:0] std_event_reg;
  reg  [14:0] std_enable_reg;
  reg  [7:0]  sre_reg;
  reg         psc_flag_reg;
  reg         opc_armed_reg;
  reg         pending_reg;
  reg  [7:0]  enabled_prev_reg;

  wire [15:0] oper_cond;
  wire [15:0] oper_ptr;
  wire [15:0] oper_ntr;
  wire [15:0] oper_event;
  wire [15:0] oper_enable;
  wire        oper_sum;
  wire [15:0] ques_cond;
  wire [15:0] ques_ptr;
  wire [15:0] ques_ntr;
  wire [15:0] ques_event;
  wire [15:0] ques_enable;
  wire        ques_sum;

  // enables cleared at restart only when the flag asks for it
  wire en_clear = power_restart & psc_flag_reg;

  // only bits captured by the read are cleared, so new events survive
  wire [15:0] oper_clr = wr_cls ? `SSR_MASK :
                         (rd_oper_ev ? prdata[15:0] : 16'h0000);
  wire [15:0] ques_clr = wr_cls ? `SSR_MASK :
                         (rd_ques_ev ? prdata[15:0] : 16'h0000);

  ssr_group u_oper (
    .pclk       (pclk),
    .presetn    (presetn),
    .cond_in    (oper_cond_in),
    .wr_ptr     (wr_oper_ptr),
    .wr_ntr     (wr_oper_ntr),
    .wr_en      (wr_oper_en),
    .wdata      (wd),
    .preset     (wr_preset),
    .en_clear   (en_clear),
    .ev_clear   (oper_clr),
    .cond       (oper_cond),
    .ptr        (oper_ptr),
    .ntr        (oper_ntr),
    .event_bits (oper_event),
    .enable     (oper_enable),
    .summary    (oper_sum)
  );

  ssr_group u_ques (
    .pclk       (pclk),
    .presetn    (presetn),
    .cond_in    (ques_cond_in),
    .wr_ptr     (wr_ques_ptr),
    .wr_ntr     (wr_ques_ntr),
    .wr_en      (wr_ques_en),
    .wdata      (wd),
    .preset     (wr_preset),
    .en_clear   (en_clear),
    .ev_clear   (ques_clr),
    .cond       (ques_cond),
    .ptr        (ques_ptr),
    .ntr        (ques_ntr),
    .event_bits (ques_event),
    .enable     (ques_enable),
    .summary    (ques_sum)
  );

  // =====================================================
  // status byte
  wire std_sum = |(std_event_reg & std_enable_reg);
  wire [7:0] stb_base;
  assign stb_base[1:0]          = 2'b00;
  assign stb_base[`SSR_SB_ERRQ] = err_queue_nonempty;
  assign stb_base[`SSR_SB_QUES] = ques_sum;
  assign stb_base[`SSR_SB_MAV]  = msg_available;
  assign stb_base[`SSR_SB_STD]  = std_sum;
  assign stb_base[`SSR_SB_RQS]  = 1'b0;
  assign stb_base[`SSR_SB_OPER] = oper_sum;

  wire [7:0] enabled     = stb_base & sre_reg;
  wire       master_summary_flag = |enabled;
  wire [7:0] stb_query   = stb_base | {1'b0, master_summary_flag, 6'b000000};
  wire [7:0] stb_poll    = stb_base | {1'b0, pending_reg, 6'b000000};
  // a request starts on a newly enabled reason only
  wire       new_reason  = |(enabled & ~enabled_prev_reg);

  // =====================================================
  // service request state
  localparam [0:0] REQ_IDLE    = 1'b0;
  localparam [0:0] REQ_PENDING = 1'b1;

  // a poll clears only a request its own captured byte reported;
  // one started after the setup cycle stays pending
  wire       poll_clear = rd_poll & prdata[`SSR_SB_RQS];
  reg  [0:0] pending_next;

  always @* begin
    pending_next = pending_reg;
    case (pending_reg)
      REQ_IDLE: begin
        if (new_reason)
          pending_next = REQ_PENDING;
      end
      REQ_PENDING: begin
        if (poll_clear)
          pending_next = REQ_IDLE;
      end
      default: pending_next = REQ_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_reg      <= REQ_IDLE;
      enabled_prev_reg <= 8'h00;
    end else begin
      pending_reg      <= pending_next;
      enabled_prev_reg <= enabled;
    end
  end

  assign srq                     = pending_reg;
  assign request_service_summary = pending_reg;

  // =====================================================
  // standard event group and common commands
  wire [14:0] std_clr = wr_cls ? 15'h7FFF : (rd_std_ev ? prdata[14:0] : 15'h0000);
  wire        opc_hit = opc_armed_reg & cmds_idle;
  wire [14:0] std_set = std_event_in | {14'h0000, opc_hit};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      std_event_reg   <= 15'h0000;
      std_enable_reg  <= 15'h0000;
      sre_reg         <= 8'h00;
      psc_flag_reg    <= `SSR_PSC_RESET;
      opc_armed_reg   <= 1'b0;
      err_queue_clear <= 1'b0;
    end else begin
      std_event_reg   <= (std_event_reg & ~std_clr) | std_set;
      err_queue_clear <= wr_cls;
      if (wr_opc)
        opc_armed_reg <= 1'b1;
      else if (opc_hit)
        opc_armed_reg <= 1'b0;
      if (wr_psc)
        psc_flag_reg <= wd[0];
      if (en_clear) begin
        std_enable_reg <= 15'h0000;
        sre_reg        <= 8'h00;
      end else begin
        if (wr_std_en)
          std_enable_reg <= wd[14:0];
        // bit 6 cannot be enabled
        if (wr_sre)
          sre_reg <= wd[7:0] & 8'hBF;
      end
    end
  end

  // =====================================================
  // read data, captured in the setup cycle
  reg [15:0] rd_mux;
  reg        rd_err;
  always @* begin
    rd_mux = 16'h0000;
    rd_err = 1'b0;
    case (paddr)
      `SSR_OPER_COND:   rd_mux = oper_cond;
      `SSR_OPER_PTR:    rd_mux = oper_ptr;
      `SSR_OPER_NTR:    rd_mux = oper_ntr;
      `SSR_OPER_EVENT:  rd_mux = oper_event;
      `SSR_OPER_ENABLE: rd_mux = oper_enable;
      `SSR_QUES_COND:   rd_mux = ques_cond;
      `SSR_QUES_PTR:    rd_mux = ques_ptr;
      `SSR_QUES_NTR:    rd_mux = ques_ntr;
      `SSR_QUES_EVENT:  rd_mux = ques_event;
      `SSR_QUES_ENABLE: rd_mux = ques_enable;
      `SSR_STD_ENABLE:  rd_mux = {1'b0, std_enable_reg};
      `SSR_STD_EVENT:   rd_mux = {1'b0, std_event_reg};
      `SSR_SRQ_ENABLE:  rd_mux = {8'h00, sre_reg};
      `SSR_STB_QUERY:   rd_mux = {8'h00, stb_query};
      `SSR_STB_POLL:    rd_mux = {8'h00, stb_poll};
      `SSR_CLEAR_CMD:   rd_mux = 16'h0000;
      `SSR_OPC_CMD:     rd_mux = 16'h0001;
      `SSR_PSC_FLAG:    rd_mux = {15'h0000, psc_flag_reg};
      `SSR_PRESET_CMD:  rd_mux = 16'h0000;
      default:          rd_err = 1'b1;
    endcase
  end

  // data and error stand from the setup cycle to the end of the access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= pwrite ? 32'h00000000 : {16'h0000, rd_mux};
      pslverr <= rd_err;
    end
  end

endmodule // ssr_status

// file: ssr_status_asserts.sv
`timescale 1ns/1ps
`include "ssr_defines.vh"
// ========
// port checker
module ssr_status_asserts (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire [14:0] oper_cond_in,
  input wire [14:0] ques_cond_in,
  input wire [14:0] std_event_in,
  input wire        err_queue_nonempty,
  input wire        msg_available,
  input wire        cmds_idle,
  input wire        power_restart,
  input wire        err_queue_clear,
  input wire        srq,
  input wire        request_service_summary
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc     = psel && penable && pready;
  wire rd_poll = acc && !pwrite && paddr == `SSR_STB_POLL;
  wire clr_wr  = acc && pwrite && paddr == `SSR_CLEAR_CMD;
  wire opc_q   = psel && penable && !pwrite && paddr == `SSR_OPC_CMD;
  wire stb_rd  = psel && penable && !pwrite && paddr == `SSR_STB_QUERY;
  sequence s_clr_wr;
    clr_wr;
  endsequence
  sequence s_pulse;
    err_queue_clear ##1 !err_queue_clear;
  endsequence
  rqs_eq_srq_a: assert property (request_service_summary == srq)
    else $error("summary bit differs from srq");
  srq_fall_poll_a: assert property ($fell(srq) |-> $past(rd_poll))
    else $error("srq dropped without a poll");
  poll_rqs_a: assert property (rd_poll |-> prdata[6] == $past(srq))
    else $error("poll bit 6 not the request flag");
  opc_wait_a: assert property (opc_q && !cmds_idle |-> !pready)
    else $error("completion query answered while busy");
  opc_done_a: assert property (opc_q && cmds_idle |-> ##[0:2] pready)
    else $error("completion query never answered");
  clr_pulse_a: assert property (s_clr_wr |=> s_pulse)
    else $error("no single queue clear pulse");
  clr_cause_a: assert property ($rose(err_queue_clear) |-> $past(clr_wr))
    else $error("queue clear without command");
  stb_fixed_a: assert property (stb_rd |-> prdata[1:0] == 2'h0
    && prdata[2] == $past(err_queue_nonempty) && prdata[4] == $past(msg_available))
    else $error("status byte low bits wrong");
  top_zero_a: assert property (prdata[31:15] == 17'h0)
    else $error("read data above bit 14 set");
endmodule // ssr_status_asserts

bind ssr_status ssr_status_asserts u_chk (.*);

// file: test_ssr_status.sv
`timescale 1ns/1ps
`include "ssr_defines.vh"
module test_ssr_status;
  reg         pclk = 1'h0;
  reg         presetn = 1'h0;
  reg         psel = 1'h0;
  reg         penable = 1'h0;
  reg         pwrite = 1'h0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0;
  reg  [31:0] q;
  reg         e_q;
  reg  [14:0] oper_cond_in = 15'h0;
  reg  [14:0] ques_cond_in = 15'h0;
  reg  [14:0] std_event_in = 15'h0;
  reg         err_queue_nonempty = 1'h0;
  reg         msg_available = 1'h0;
  reg         cmds_idle = 1'h1;
  reg         power_restart = 1'h0;
  wire        pready;
  wire        pslverr;
  wire        err_queue_clear;
  wire        srq;
  wire        request_service_summary;
  wire        poll_due;
  wire [31:0] prdata;
  integer     error_cnt = 0;
  integer     samples_checked = 0;
  integer     cyc = 0;
  integer     i;
  always #25 pclk = ~pclk;
  ssr_status u_ssr_status (.*);
  ssr_ctrl_model u_ssr_ctrl_model (.pclk(pclk), .presetn(presetn), .srq(srq),
    .poll_due(poll_due));
  // ========
  // checking and closing
  task tally_and_finish;
    begin
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: %h expected %h", $time, s, e);
      end
    end
  endtask
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      error_cnt = error_cnt + 1;
      tally_and_finish;
    end
  end
  // ========
  // apb master
  task xf(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      q = prdata;
      e_q = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  task rc(input [7:0] a, input [31:0] e);
    begin
      xf(1'h0, a, 32'h0);
      chk(q, e);
    end
  endtask
  task pr;
    begin
      power_restart <= 1'h1;
      @(posedge pclk);
      power_restart <= 1'h0;
    end
  endtask
  // ========
  // scenarios
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    rc(`SSR_OPER_PTR, 32'h7FFF);
    rc(`SSR_OPER_NTR, 32'h0);
    rc(`SSR_PSC_FLAG, 32'h1);
    xf(1'h1, `SSR_OPER_PTR, 32'hFFFF);
    rc(`SSR_OPER_PTR, 32'h7FFF);
    xf(1'h1, `SSR_SRQ_ENABLE, 32'hA0);
    rc(`SSR_SRQ_ENABLE, 32'hA0);
    oper_cond_in <= 15'h008C;
    repeat (3) @(posedge pclk);
    rc(`SSR_OPER_COND, 32'h8C);
    oper_cond_in <= 15'h0;
    repeat (3) @(posedge pclk);
    rc(`SSR_OPER_COND, 32'h0);
    rc(`SSR_OPER_EVENT, 32'h8C);
    rc(`SSR_OPER_EVENT, 32'h0);
    xf(1'h1, `SSR_OPER_NTR, 32'h1);
    xf(1'h1, `SSR_OPER_PTR, 32'h0);
    oper_cond_in <= 15'h1;
    repeat (3) @(posedge pclk);
    oper_cond_in <= 15'h0;
    repeat (3) @(posedge pclk);
    rc(`SSR_OPER_EVENT, 32'h1);
    xf(1'h1, `SSR_PRESET_CMD, 32'h0);
    rc(`SSR_OPER_PTR, 32'h7FFF);
    rc(`SSR_OPER_NTR, 32'h0);
    xf(1'h1, `SSR_OPER_ENABLE, 32'h1);
    err_queue_nonempty <= 1'h1;
    msg_available <= 1'h1;
    oper_cond_in <= 15'h1;
    for (i = 0; i < 20 && poll_due !== 1'h1; i = i + 1) @(posedge pclk);
    chk({31'h0, srq}, 32'h1);
    chk({31'h0, request_service_summary}, 32'h1);
    rc(`SSR_STB_QUERY, 32'hD4);
    rc(`SSR_STB_QUERY, 32'hD4);
    chk({31'h0, srq}, 32'h1);
    rc(`SSR_STB_POLL, 32'hD4);
    rc(`SSR_STB_POLL, 32'h94);
    chk({31'h0, srq}, 32'h0);
    xf(1'h1, `SSR_CLEAR_CMD, 32'h0);
    rc(`SSR_OPER_EVENT, 32'h0);
    rc(`SSR_STB_QUERY, 32'h14);
    xf(1'h1, `SSR_QUES_ENABLE, 32'h2);
    ques_cond_in <= 15'h2;
    repeat (3) @(posedge pclk);
    rc(`SSR_QUES_COND, 32'h2);
    rc(`SSR_STB_QUERY, 32'h1C);
    rc(`SSR_QUES_EVENT, 32'h2);
    rc(`SSR_STB_QUERY, 32'h14);
    ques_cond_in <= 15'h0;
    xf(1'h1, `SSR_STD_ENABLE, 32'h8);
    std_event_in <= 15'h8;
    @(posedge pclk);
    std_event_in <= 15'h0;
    repeat (2) @(posedge pclk);
    rc(`SSR_STD_ENABLE, 32'h8);
    rc(`SSR_STB_QUERY, 32'h74);
    rc(`SSR_STD_EVENT, 32'h8);
    rc(`SSR_STD_EVENT, 32'h0);
    cmds_idle <= 1'h0;
    xf(1'h1, `SSR_OPC_CMD, 32'h1);
    fork
      xf(1'h0, `SSR_OPC_CMD, 32'h0);
      begin
        repeat (6) @(posedge pclk);
        cmds_idle <= 1'h1;
      end
    join
    chk(q, 32'h1);
    rc(`SSR_STD_EVENT, 32'h1);
    pr;
    rc(`SSR_SRQ_ENABLE, 32'h0);
    rc(`SSR_STD_ENABLE, 32'h0);
    rc(`SSR_OPER_ENABLE, 32'h0);
    xf(1'h1, `SSR_PSC_FLAG, 32'h0);
    xf(1'h1, `SSR_SRQ_ENABLE, 32'hA0);
    pr;
    rc(`SSR_SRQ_ENABLE, 32'hA0);
    xf(1'h0, 8'hFC, 32'h0);
    chk({31'h0, e_q}, 32'h1);
    tally_and_finish;
  end
endmodule // test_ssr_status
